/* pkg/brake_pkg.sv */
package brake_pkg;

  // ==========================================================
  // Register indices
  localparam logic [7:0]  IDX_PARAM_COUNT  = 8'h00;
  localparam logic [7:0]  IDX_CLOSE_IDLE   = 8'h01;
  localparam logic [7:0]  IDX_SHUT_IDLE    = 8'h02;
  localparam logic [7:0]  IDX_OPEN_DELAY   = 8'h03;
  localparam logic [7:0]  IDX_START_DELAY  = 8'h04;
  localparam logic [7:0]  IDX_PWM_FREQ     = 8'h05;
  localparam logic [7:0]  IDX_PWM_DUTY     = 8'h06;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  RST_PARAM_COUNT  = 8'h06;
  localparam logic [31:0] RST_CLOSE_IDLE   = 32'h0000_03E8;
  localparam logic [31:0] RST_SHUT_IDLE    = 32'h0000_03E8;
  localparam logic [31:0] RST_OPEN_DELAY   = 32'h0000_03E8;
  localparam logic [31:0] RST_START_DELAY  = 32'h0000_0000;
  localparam logic [31:0] RST_PWM_FREQ     = 32'h0000_0000;
  localparam logic [31:0] RST_PWM_DUTY     = 32'h0000_0000;

  // ==========================================================
  // Accepted ranges
  localparam logic [31:0] PWM_FREQ_MAX     = 32'h0000_07D0;
  localparam logic [31:0] PWM_DUTY_MIN     = 32'h0000_0002;
  localparam logic [31:0] PWM_DUTY_MAX     = 32'h0000_0064;

  // ==========================================================
  // Timing
  localparam int          CLK_HZ           = 25_000_000;
  localparam int          CLK_NS           = 40;
  localparam int          TICK_NS          = 1_000_000;
  localparam int          TICK_CYCLES      = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int          PCT_STEP         = CLK_HZ / 100;
  localparam int          PHASE_W          = 25;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_OFF        = 3'h0,
    ST_OPEN_WAIT  = 3'h1,
    ST_START_WAIT = 3'h3,
    ST_OPERATE    = 3'h2,
    ST_CLOSE_WAIT = 3'h6,
    ST_SHUT_WAIT  = 3'h4
  } seq_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  index;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } reg_rsp_t;

endpackage : brake_pkg

/* src/brake_pwm.sv */
`timescale 1ns/1ps
module brake_pwm
  import brake_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        enable,
  input  wire logic [10:0] freq_hz,
  input  wire logic [6:0]  duty_pct,
  output logic             pwm_out
);

  // ==========================================================
  // Phase accumulator
  // Adding the frequency each cycle and wrapping at the clock rate
  // avoids a hardware divider; period jitter is one clock at most.
  localparam logic [PHASE_W-1:0] WRAP = PHASE_W'(CLK_HZ);
  localparam logic [PHASE_W-1:0] STEP = PHASE_W'(PCT_STEP);

  logic [PHASE_W-1:0] phase;
  wire  [PHASE_W-1:0] sum       = phase + PHASE_W'(freq_hz);
  wire  [PHASE_W-1:0] next_phase = (sum >= WRAP) ? sum - WRAP : sum;
  wire  [PHASE_W-1:0] threshold = PHASE_W'(duty_pct * STEP);
  // Zero frequency or zero duty leaves the brake held fully open
  wire                steady    = (freq_hz == 11'h000) ||
                                  (duty_pct == 7'h00);
  wire                next_out  = enable &
                                  (steady | (phase < threshold));

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase   <= '0;
      pwm_out <= 1'b0;
    end else begin
      phase   <= enable ? next_phase : '0;
      pwm_out <= next_out;
    end
  end

endmodule : brake_pwm

/* src/holding_brake_sequencer.sv */
`timescale 1ns/1ps
module holding_brake_sequencer
  import brake_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       power_request,
  input  wire logic       motor_standstill,
  input  wire reg_req_t   reg_req,
  output reg_rsp_t        reg_rsp,
  output logic            current_on,
  output logic            brake_open,
  output logic            brake_drive,
  output logic            operation_enabled,
  output seq_state_t      seq_state
);

  // ==========================================================
  // Parameter registers
  logic [31:0] close_idle;
  logic [31:0] shut_idle;
  logic [31:0] open_delay;
  logic [31:0] start_delay;
  logic [31:0] pwm_freq;
  logic [31:0] pwm_duty;

  wire hit_close = reg_req.index == IDX_CLOSE_IDLE;
  wire hit_shut  = reg_req.index == IDX_SHUT_IDLE;
  wire hit_open  = reg_req.index == IDX_OPEN_DELAY;
  wire hit_start = reg_req.index == IDX_START_DELAY;
  wire hit_freq  = reg_req.index == IDX_PWM_FREQ;
  wire hit_duty  = reg_req.index == IDX_PWM_DUTY;
  wire hit_count = reg_req.index == IDX_PARAM_COUNT;
  wire hit_any   = hit_close | hit_shut | hit_open | hit_start |
                   hit_freq | hit_duty | hit_count;

  // Out-of-range values are refused and the old setting kept
  wire freq_ok   = reg_req.wdata <= PWM_FREQ_MAX;
  wire duty_ok   = (reg_req.wdata == 32'h0000_0000) ||
                   ((reg_req.wdata >= PWM_DUTY_MIN) &&
                    (reg_req.wdata <= PWM_DUTY_MAX));

  wire wr_close  = reg_req.wr & hit_close;
  wire wr_shut   = reg_req.wr & hit_shut;
  wire wr_open   = reg_req.wr & hit_open;
  wire wr_start  = reg_req.wr & hit_start;
  wire wr_freq   = reg_req.wr & hit_freq & freq_ok;
  wire wr_duty   = reg_req.wr & hit_duty & duty_ok;

  // Writes to the count, unknown indices or bad values answer err
  wire wr_bad    = reg_req.wr & (~hit_any | hit_count |
                   (hit_freq & ~freq_ok) | (hit_duty & ~duty_ok));
  wire rd_bad    = reg_req.rd & ~hit_any;

  // Reads have no side effects, so any defined index may be read back
  wire [31:0] rd_mux =
    hit_count ? {24'h00_0000, RST_PARAM_COUNT} :
    hit_close ? close_idle  :
    hit_shut  ? shut_idle   :
    hit_open  ? open_delay  :
    hit_start ? start_delay :
    hit_freq  ? pwm_freq    :
    hit_duty  ? pwm_duty    : 32'h0000_0000;

  // One short process per setting; the count entry is a constant
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)       close_idle <= RST_CLOSE_IDLE;
    else if (wr_close) close_idle <= reg_req.wdata;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)      shut_idle <= RST_SHUT_IDLE;
    else if (wr_shut) shut_idle <= reg_req.wdata;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)      open_delay <= RST_OPEN_DELAY;
    else if (wr_open) open_delay <= reg_req.wdata;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)       start_delay <= RST_START_DELAY;
    else if (wr_start) start_delay <= reg_req.wdata;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)      pwm_freq <= RST_PWM_FREQ;
    else if (wr_freq) pwm_freq <= reg_req.wdata;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)      pwm_duty <= RST_PWM_DUTY;
    else if (wr_duty) pwm_duty <= reg_req.wdata;
  end

  // ==========================================================
  // Register port answer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rsp <= '0;
    end else begin
      reg_rsp.ack   <= reg_req.wr | reg_req.rd;
      reg_rsp.err   <= wr_bad | rd_bad;
      reg_rsp.rdata <= reg_req.rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Millisecond tick and interval counter
  logic [31:0] tick_div;
  logic [31:0] ms_left;
  seq_state_t  next_state;

  wire         load      = next_state != seq_state;
  wire         tick      = tick_div == 32'(TICK_LEN - 1);
  wire         time_done = ms_left == 32'h0000_0000;

  // Each phase's interval is chosen by the phase being entered
  wire [31:0] load_ms =
    (next_state == ST_OPEN_WAIT)  ? open_delay  :
    (next_state == ST_START_WAIT) ? start_delay :
    (next_state == ST_CLOSE_WAIT) ? close_idle  :
    (next_state == ST_SHUT_WAIT)  ? shut_idle   : 32'h0000_0000;

  // Divider restarts on load so an interval of N lasts N ms plus one clock
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tick_div <= 32'h0000_0000;
      ms_left  <= 32'h0000_0000;
    end else if (load) begin
      tick_div <= 32'h0000_0000;
      ms_left  <= load_ms;
    end else begin
      tick_div <= tick ? 32'h0000_0000 : tick_div + 32'h0000_0001;
      // Held at zero once spent, so it cannot wrap in long phases
      if (tick && !time_done) ms_left <= ms_left - 32'h0000_0001;
    end
  end

  // ==========================================================
  // Sequencer
  always_comb begin
    next_state = seq_state;
    case (seq_state)
      ST_OFF: begin
        if (power_request) next_state = ST_OPEN_WAIT;
      end
      ST_OPEN_WAIT: begin
        // Requests are not looked at until both waits have run out
        if (time_done) next_state = ST_START_WAIT;
      end
      ST_START_WAIT: begin
        if (time_done) next_state = ST_OPERATE;
      end
      ST_OPERATE: begin
        if (!power_request && motor_standstill) begin
          next_state = ST_CLOSE_WAIT;
        end
      end
      ST_CLOSE_WAIT: begin
        // Renewed request or motion aborts while the brake is open
        if (power_request || !motor_standstill) begin
          next_state = ST_OPERATE;
        end else if (time_done) begin
          next_state = ST_SHUT_WAIT;
        end
      end
      ST_SHUT_WAIT: begin
        // Current stays on until the brake has surely closed
        if (time_done) next_state = ST_OFF;
      end
      default: next_state = ST_OFF;
    endcase
  end

  // ==========================================================
  // Drive outputs
  // Outputs follow the state being entered, so they change together
  wire next_current = next_state != ST_OFF;
  wire next_brake   = (next_state == ST_START_WAIT) ||
                      (next_state == ST_OPERATE)    ||
                      (next_state == ST_CLOSE_WAIT);
  wire next_oper    = next_state == ST_OPERATE;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seq_state         <= ST_OFF;
      current_on        <= 1'b0;
      brake_open        <= 1'b0;
      operation_enabled <= 1'b0;
    end else begin
      seq_state         <= next_state;
      current_on        <= next_current;
      brake_open        <= next_brake;
      operation_enabled <= next_oper;
    end
  end

  // ==========================================================
  // Brake drive
  // PWM runs only while the brake is commanded open
  brake_pwm u_pwm (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .enable   (brake_open),
    .freq_hz  (pwm_freq[10:0]),
    .duty_pct (pwm_duty[6:0]),
    .pwm_out  (brake_drive)
  );

endmodule : holding_brake_sequencer

/* dv/brake_plant.sv */
`timescale 1ns/1ps
module brake_plant #(
  parameter int SETTLE = 6
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic current_on,
  input  wire logic coast,
  output logic      motor_standstill
);
  // ==========================================================
  // Motor coasts down over SETTLE cycles once torque is gone
  int cnt;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) cnt <= SETTLE;
    else if (current_on && !coast) cnt <= 0;
    else if (cnt < SETTLE) cnt <= cnt + 1;
  end
  assign motor_standstill = (cnt == SETTLE);
endmodule : brake_plant

/* dv/brake_seq_sva.sv */
`timescale 1ns/1ps
module brake_seq_sva
  import brake_pkg::*;
#(
  parameter int TICK_LEN = 4
) (
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic       power_request,
  input wire logic       motor_standstill,
  input wire reg_req_t   reg_req,
  input wire reg_rsp_t   reg_rsp,
  input wire logic       current_on,
  input wire logic       brake_open,
  input wire logic       brake_drive,
  input wire logic       operation_enabled,
  input wire seq_state_t seq_state
);
  // ==========================================================
  // Sequencing and refusal checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence stop_seen;
    seq_state == ST_OPERATE && !power_request && motor_standstill;
  endsequence
  sequence wr_at(logic [7:0] i);
    reg_req.wr && reg_req.index == i;
  endsequence
  chk_current_first: assert property (
    $rose(current_on) |-> !brake_open) else $error("brake open early");
  chk_op_needs_open: assert property (
    operation_enabled |-> brake_open && current_on)
    else $error("operation without open brake");
  chk_stop_drops_op: assert property (
    stop_seen |-> ##[1:2] !operation_enabled) else $error("op stays");
  chk_close_holds: assert property (
    $rose(seq_state == ST_CLOSE_WAIT) |-> brake_open && current_on)
    else $error("brake closed without idle wait");
  chk_close_keeps_cur: assert property (
    $fell(brake_open) |-> current_on) else $error("current off early");
  chk_off_after_close: assert property (
    $fell(current_on) |-> !brake_open) else $error("brake still open");
  chk_drive_closed: assert property (
    !brake_open |=> !brake_drive) else $error("drive while closed");
  chk_freq_refused: assert property (
    wr_at(IDX_PWM_FREQ) ##0 (reg_req.wdata > PWM_FREQ_MAX)
    |=> reg_rsp.ack && reg_rsp.err) else $error("bad freq taken");
  chk_duty_refused: assert property (
    wr_at(IDX_PWM_DUTY) ##0 (reg_req.wdata == 32'h1 ||
    reg_req.wdata > PWM_DUTY_MAX) |=> reg_rsp.ack && reg_rsp.err)
    else $error("bad duty taken");
endmodule : brake_seq_sva

bind holding_brake_sequencer brake_seq_sva #(.TICK_LEN(TICK_LEN)) u_sva (
  .clk_sys(clk_sys), .resetn(resetn), .power_request(power_request),
  .motor_standstill(motor_standstill), .reg_req(reg_req),
  .reg_rsp(reg_rsp), .current_on(current_on), .brake_open(brake_open),
  .brake_drive(brake_drive), .operation_enabled(operation_enabled),
  .seq_state(seq_state));

/* dv/holding_brake_sequencer_tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module holding_brake_sequencer_tb;
  import brake_pkg::*;
  localparam int T = 4;
  logic clk_sys, resetn, power_request, stop_req, motor_standstill;
  logic current_on, brake_open, brake_drive, operation_enabled;
  reg_req_t   reg_req;
  reg_rsp_t   reg_rsp;
  seq_state_t seq_state;
  int         bad_count, total_checks, n;
  wire [3:0]  obs = {operation_enabled, brake_open, current_on, brake_drive};
  holding_brake_sequencer #(.TICK_LEN(T)) u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .power_request(power_request),
    .motor_standstill(motor_standstill), .reg_req(reg_req),
    .reg_rsp(reg_rsp), .current_on(current_on), .brake_open(brake_open),
    .brake_drive(brake_drive), .operation_enabled(operation_enabled),
    .seq_state(seq_state));
  brake_plant #(.SETTLE(6)) u_plant (.clk_sys(clk_sys), .resetn(resetn),
    .current_on(current_on), .coast(stop_req),
    .motor_standstill(motor_standstill));
  initial begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // Shared access and timing tasks
  task acc(input logic w, input logic [7:0] i, input logic [31:0] d,
           input logic [31:0] x, input logic e);
    reg_req = '{wr: w, rd: !w, index: i, wdata: d};
    @(negedge clk_sys);
    `CHK(reg_rsp.ack, 1'b1)
    `CHK(reg_rsp.err, e)
    if (!w) `CHK(reg_rsp.rdata, x)
  endtask : acc
  task span(input int b, input logic v, output int k);
    k = 0;
    while (obs[b] !== v && k < 20000) begin
      @(negedge clk_sys);
      k++;
    end
    if (k == 20000) `CHK(obs[b], v)
  endtask : span
  // ==========================================================
  // Scenarios
  task t_regs;
    logic [31:0] dflt [7] = '{32'h6, 32'h3E8, 32'h3E8, 32'h3E8, 0, 0, 0};
    for (int i = 0; i < 7; i++) acc(0, i[7:0], 0, dflt[i], 0);
    acc(0, 8'h07, 0, 0, 1);
    acc(1, IDX_PARAM_COUNT, 32'h9, 0, 1);
    acc(1, IDX_PWM_FREQ, 32'h7D1, 0, 1);
    acc(0, IDX_PWM_FREQ, 0, 0, 0);
    acc(1, IDX_PWM_FREQ, 32'h7D0, 0, 0);
    acc(1, IDX_PWM_DUTY, 32'h1, 0, 1);
    acc(1, IDX_PWM_DUTY, 32'h65, 0, 1);
    acc(0, IDX_PWM_DUTY, 0, 0, 0);
    acc(1, IDX_PWM_DUTY, 32'h64, 0, 0);
    acc(0, IDX_PWM_DUTY, 0, 32'h64, 0);
    acc(1, IDX_PWM_DUTY, 32'h0, 0, 0);
    acc(0, IDX_PWM_FREQ, 0, 32'h7D0, 0);
    acc(1, IDX_OPEN_DELAY, 32'h2, 0, 0);
    acc(1, IDX_START_DELAY, 32'h1, 0, 0);
    acc(1, IDX_CLOSE_IDLE, 32'h1, 0, 0);
    acc(1, IDX_SHUT_IDLE, 32'h2, 0, 0);
    reg_req = '0;
    $display("t_regs done");
  endtask : t_regs
  task t_power_up;
    power_request = 1;
    span(1, 1, n);
    `CHK(brake_open, 1'b0)
    `CHK(seq_state, ST_OPEN_WAIT)
    span(2, 1, n);
    `CHK(n, 2 * T + 1)
    `CHK(seq_state, ST_START_WAIT)
    span(3, 1, n);
    `CHK(n, T + 1)
    `CHK(brake_drive, 1'b1)
    $display("t_power_up done");
  endtask : t_power_up
  task t_pwm;
    int hi, rises;
    logic prev;
    logic [31:0] dl [2] = '{32'h32, 32'h2};
    foreach (dl[j]) begin
      acc(1, IDX_PWM_DUTY, dl[j], 0, 0);
      reg_req = '0;
      repeat (12500) @(negedge clk_sys);
      hi = 0;
      rises = 0;
      prev = brake_drive;
      repeat (12500) begin
        @(negedge clk_sys);
        if (brake_drive === 1'b1) hi++;
        if (brake_drive === 1'b1 && prev === 1'b0) rises++;
        prev = brake_drive;
      end
      `CHK(hi, int'(dl[j]) * 125)
      `CHK(rises, 1)
    end
    $display("t_pwm done");
  endtask : t_pwm
  task t_power_down;
    power_request = 0;
    stop_req = 1;
    span(3, 0, n);
    power_request = 1;
    span(3, 1, n);
    `CHK(n, 1)
    `CHK(brake_open, 1'b1)
    power_request = 0;
    span(3, 0, n);
    span(2, 0, n);
    `CHK(n, T + 1)
    `CHK(current_on, 1'b1)
    `CHK(seq_state, ST_SHUT_WAIT)
    span(1, 0, n);
    `CHK(n, 2 * T + 1)
    `CHK(brake_drive, 1'b0)
    `CHK(seq_state, ST_OFF)
    $display("t_power_down done");
  endtask : t_power_down
  // ==========================================================
  // Run control
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  initial begin
    #(40 * 80000);
    bad_count++;
    finish_test;
  end
  initial begin
    {power_request, stop_req, resetn, bad_count, total_checks} = '0;
    reg_req = '0;
    repeat (3) @(negedge clk_sys);
    resetn = 1;
    @(negedge clk_sys);
    t_regs;
    t_power_up;
    t_pwm;
    t_power_down;
    finish_test;
  end
endmodule : holding_brake_sequencer_tb
